// >>> pkg/flut_defines.vh
`ifndef FLUT_DEFINES_VH
`define FLUT_DEFINES_VH
// Register word indices; the bus byte address is index*4
`define FLUT_IDX_SP3      8'h54
`define FLUT_IDX_DUTY3    8'h55
`define FLUT_IDX_SP4      8'h56
`define FLUT_IDX_DUTY4    8'h57
// Own control/status words
`define FLUT_IDX_CTRL     8'h60
`define FLUT_IDX_TEMP     8'h61
`define FLUT_IDX_STAT     8'h62
// Reset values
`define FLUT_SP_RST       8'h7f
`define FLUT_DUTY_RST     8'h3f
`define FLUT_CTRL_RST     8'h00
// Control field positions
`define FLUT_CTRL_WEN     5
`define FLUT_CTRL_THI     0
`define FLUT_CTRL_DHI     1
`define FLUT_CTRL_F22K    2
// Field positions inside entry registers
`define FLUT_SP_HALF_BIT  7
`define FLUT_DUTY_EXT_LSB 6
`endif

// >>> logic/flut_entry.v
`timescale 1ns/100ps
`default_nettype none
`include "flut_defines.vh"
// One setpoint/duty pair: storage, read masking and compare
module flut_entry (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wr_sp_i,
	input  wire        wr_duty_i,
	input  wire [7:0]  wdata_i,
	input  wire        temp_hi_i,
	input  wire        duty_hi_i,
	input  wire        f22k_i,
	input  wire [8:0]  temp_i,
	input  wire [8:0]  offset_i,
	output wire [7:0]  sp_rd_o,
	output wire [7:0]  duty_rd_o,
	output wire        above_o,
	output wire [7:0]  duty_o
);
	reg  [7:0]  sp_r;
	reg  [7:0]  duty_r;
	wire [7:0]  sp_eff;
	wire [9:0]  limit;
	wire [9:0]  temp_cmp;

	// Storage, loaded with the power-on values
	always @(posedge clk_i) begin
		if (rst_i) begin
			sp_r   <= `FLUT_SP_RST;
			duty_r <= `FLUT_DUTY_RST;
		end else begin
			if (wr_sp_i)
				sp_r <= wdata_i;
			if (wr_duty_i)
				duty_r <= wdata_i;
		end
	end

	// Low resolution hides top bits both in use and on reads
	assign sp_eff    = temp_hi_i ? sp_r : {1'b0, sp_r[6:0]};
	assign sp_rd_o   = sp_eff;
	assign duty_rd_o = duty_hi_i ? duty_r
		: {2'b00, duty_r[5:0]};

	// Threshold in half degrees; low res is whole degrees
	// Sign is zero so plain unsigned compare, offset widens range
	assign limit = temp_hi_i
		? ({2'b00, sp_eff} + {1'b0, offset_i})
		: ({2'b00, sp_eff[6:0], 1'b0}
		   + {1'b0, offset_i});
	// Nine bits in high res, eight (half bit dropped) in low res
	assign temp_cmp = temp_hi_i ? {1'b0, temp_i}
		: {1'b0, temp_i[8:1], 1'b0};
	assign above_o  = temp_cmp > limit;

	// Extended duty bits only count at 22.5 kHz in high res
	assign duty_o = (duty_hi_i && f22k_i) ? duty_r
		: {2'b00, duty_r[5:0]};
endmodule // flut_entry
`default_nettype wire

// >>> logic/flut_wb_slave.v
`timescale 1ns/100ps
`default_nettype none
// Classic Wishbone handshake: ack one cycle after a strobe, then drops
module flut_wb_slave (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	output wire        wr_o,
	output reg         ack_o
);
	// One-cycle ack; a held request is not re-acked back to back
	always @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i && stb_i && !ack_o;
	end
	// Write takes effect on the acking edge only
	assign wr_o = cyc_i && stb_i && we_i && ack_o;
endmodule // flut_wb_slave
`default_nettype wire

// >>> logic/flut_top.v
`timescale 1ns/100ps
`default_nettype none
`include "flut_defines.vh"
module flut_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [9:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output wire        ack_o,
	input  wire [8:0]  remote_temp_i,
	input  wire [8:0]  lut_offset_i,
	output reg  [7:0]  fan_duty_o,
	output reg         fan_duty_valid_o
);
	reg  [7:0]  ctrl_r;
	wire        wr;
	wire [7:0]  idx;
	wire        wr_ok;
	wire [7:0]  sp3_rd;
	wire [7:0]  d3_rd;
	wire [7:0]  sp4_rd;
	wire [7:0]  d4_rd;
	wire        above3;
	wire        above4;
	wire [7:0]  duty3;
	wire [7:0]  duty4;
	reg  [7:0]  rd_nxt;
	reg  [7:0]  duty_nxt;

	flut_wb_slave u_bus (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.we_i  (we_i),
		.wr_o  (wr),
		.ack_o (ack_o)
	);

	// Word index from the byte address; only lane 0 carries data
	assign idx   = adr_i[9:2];
	assign wr_ok = wr && sel_i[0] && ctrl_r[`FLUT_CTRL_WEN];

	// Control word: write enable, resolution modes, PWM frequency
	always @(posedge clk_i) begin
		if (rst_i)
			ctrl_r <= `FLUT_CTRL_RST;
		else if (wr && sel_i[0] && idx == `FLUT_IDX_CTRL)
			ctrl_r <= dat_i[7:0];
	end

	flut_entry u_e3 (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_sp_i   (wr_ok && idx == `FLUT_IDX_SP3),
		.wr_duty_i (wr_ok && idx == `FLUT_IDX_DUTY3),
		.wdata_i   (dat_i[7:0]),
		.temp_hi_i (ctrl_r[`FLUT_CTRL_THI]),
		.duty_hi_i (ctrl_r[`FLUT_CTRL_DHI]),
		.f22k_i    (ctrl_r[`FLUT_CTRL_F22K]),
		.temp_i    (remote_temp_i),
		.offset_i  (lut_offset_i),
		.sp_rd_o   (sp3_rd),
		.duty_rd_o (d3_rd),
		.above_o   (above3),
		.duty_o    (duty3)
	);

	flut_entry u_e4 (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_sp_i   (wr_ok && idx == `FLUT_IDX_SP4),
		.wr_duty_i (wr_ok && idx == `FLUT_IDX_DUTY4),
		.wdata_i   (dat_i[7:0]),
		.temp_hi_i (ctrl_r[`FLUT_CTRL_THI]),
		.duty_hi_i (ctrl_r[`FLUT_CTRL_DHI]),
		.f22k_i    (ctrl_r[`FLUT_CTRL_F22K]),
		.temp_i    (remote_temp_i),
		.offset_i  (lut_offset_i),
		.sp_rd_o   (sp4_rd),
		.duty_rd_o (d4_rd),
		.above_o   (above4),
		.duty_o    (duty4)
	);

	// Read mux; unmapped words read zero and still ack
	always @* begin
		case (idx)
		`FLUT_IDX_SP3:   rd_nxt = sp3_rd;
		`FLUT_IDX_DUTY3: rd_nxt = d3_rd;
		`FLUT_IDX_SP4:   rd_nxt = sp4_rd;
		`FLUT_IDX_DUTY4: rd_nxt = d4_rd;
		`FLUT_IDX_CTRL:  rd_nxt = ctrl_r;
		`FLUT_IDX_TEMP:  rd_nxt = remote_temp_i[8:1];
		`FLUT_IDX_STAT:  rd_nxt = {6'h00, above4, above3};
		default:         rd_nxt = 8'h00;
		endcase
	end

	// Higher entry wins, as in a rising lookup table
	always @* begin
		if (above4)
			duty_nxt = duty4;
		else
			duty_nxt = duty3;
	end

	// Registered outputs; read data latched with the ack
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o            <= 32'h00000000;
			fan_duty_o       <= 8'h00;
			fan_duty_valid_o <= 1'b0;
		end else begin
			if (cyc_i && stb_i && !ack_o)
				dat_o <= {24'h000000, rd_nxt};
			fan_duty_o       <= duty_nxt;
			fan_duty_valid_o <= above3 || above4;
		end
	end
endmodule // flut_top
`default_nettype wire

// >>> testbench/flut_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Bus handshake and readback checks on the top ports
module flut_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [9:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [8:0]  remote_temp_i,
	input wire logic        fan_duty_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request held and read completion
	wire rq = cyc_i && stb_i;
	wire rd = rq && !we_i && ack_o;
	a_ack_next: assert property (rq && !ack_o |=> ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_no_stray: assert property (!rq |=> !ack_o)
		else $error("stray ack");
	a_high_zero: assert property (rd |-> dat_o[31:8] == 0)
		else $error("upper bits set");
	a_unmapped_zero: assert property (rd && adr_i[9:2] > 8'h62 |-> !dat_o)
		else $error("unmapped not zero");
	a_temp_read: assert property (rd && adr_i[9:2] == 8'h61
		|-> dat_o[7:0] == $past(remote_temp_i[8:1])) else $error("temp");
	a_cold_idle: assert property (!$past(remote_temp_i) |->
		!fan_duty_valid_o) else $error("valid when cold");
	a_data_hold: assert property (!rq |=> $stable(dat_o))
		else $error("dat_o moved");
	c_write: cover property (rq && we_i && ack_o);
	c_hot: cover property (fan_duty_valid_o);
	c_unmap: cover property (rd && adr_i[9:2] > 8'h62);
endmodule // flut_chk
bind flut_top flut_chk i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .dat_o, .ack_o, .remote_temp_i, .fan_duty_valid_o);
`default_nettype wire

// >>> testbench/flut_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [9:0]  adr_i = 0;
	logic [3:0]  sel_i = 0;
	logic [31:0] dat_i = 0;
	logic [8:0]  tp = 0, of = 0;
	logic [7:0]  q;
	wire  [31:0] dat_o;
	wire  [7:0]  fd;
	wire         ack_o, fv;
	bit   [31:0] s = 32'h6a16;
	int n_errors = 0, compares = 0, c, a3, a4, x;
	int r[4] = '{8'h7f, 8'h3f, 8'h7f, 8'h3f};
	// Five mixes of temp res, duty res and PWM frequency, all with write enable set
	int md[5] = '{8'h20, 8'h27, 8'h23, 8'h25, 8'h26};
	flut_top i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .remote_temp_i(tp), .lut_offset_i(of),
		.fan_duty_o(fd), .fan_duty_valid_o(fv));
	always #10 clk_i = ~clk_i;
	function automatic int xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic print_verdict();
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string n, int e, logic [8:0] g);
		compares++;
		if (g !== e[8:0]) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", n, e[8:0], g);
		end
	endtask
	// Held until ack is sampled, so slow answers are waited out
	task automatic bus(logic [9:0] a, int d, logic w, logic [3:0] sl);
		int n;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, sl, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 9);
		q = dat_o[7:0];
		{cyc_i, stb_i} <= 2'b00;
		// A missing ack is a mismatch and ends the run here
		if (ack_o !== 1'b1) begin
			n_errors++;
			print_verdict();
		end
	endtask
	// Readback masks follow the current resolution modes
	function automatic int m(int i);
		return r[i] & (i[0] ? (c[1] ? 8'hff : 8'h3f) : (c[0] ? 8'hff : 8'h7f));
	endfunction
	function automatic int th(int i);
		return (c[0] ? r[2*i] : (r[2*i] & 8'h7f) * 2) + of;
	endfunction
	initial begin
		c = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 5; i++) begin
			if (i == 4) bus(10'h150, 8'h12, 1'b1, 4'h1);
			bus(10'h150 + 10'(4 * (i & 3)), 0, 1'b0, 4'h1);
			chk("entry", m(i & 3), 9'(q));
		end
		for (int k = 0; k < 5; k++) begin
			c = md[k];
			bus(10'h180, c, 1'b1, 4'h1);
			bus(10'h180, 0, 1'b0, 4'h1);
			chk("ctrl", c, 9'(q));
			for (int i = 0; i < 4; i++) begin
				x = xs() & 8'hff;
				bus(10'h150 + 10'(4 * i), ~x, 1'b1, 4'h0);
				bus(10'h150 + 10'(4 * i), x, 1'b1, 4'h1);
				r[i] = x;
				bus(10'h150 + 10'(4 * i), 0, 1'b0, 4'h1);
				chk("entry", m(i), 9'(q));
			end
			// Random temperatures sweep both thresholds
			for (int j = 0; j < 40; j++) begin
				@(posedge clk_i);
				tp <= 9'(xs());
				of <= 9'(xs() & 8'h3f);
				repeat (2) @(posedge clk_i);
				#1;
				x = c[0] ? tp : tp & 9'h1fe;
				a4 = x > th(1);
				a3 = x > th(0);
				chk("valid", a4 | a3, 9'(fv));
				x = c[1] && c[2] ? 8'hff : 8'h3f;
				chk("duty", r[a4 ? 3 : 1] & x, 9'(fd));
				bus(10'h188, 0, 1'b0, 4'h1);
				chk("status", 2 * a4 + a3, 9'(q));
			end
		end
		bus(10'h3fc, 0, 1'b0, 4'h1);
		chk("unmapped", 0, 9'(q));
		bus(10'h184, 0, 1'b0, 4'h1);
		chk("temp", tp[8:1], 9'(q));
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
